// ==== verilog/usc_top.sv ====
`timescale 1ns/10ps
// Function
// - Break alias is a second path to line control bit 6; forces spacing.
// - Without loopback, serial output stays low while break is set.
// - Without loopback, infrared mode with break keeps the infrared output pulsing.
// - Loopback routes break to our own receiver, not the pin.
// - Transfer-mode alias is fifo control bit 3; writes touch nothing else.
// - Transfer-mode 0 and 1 select the two request signalling modes.
// - FIFO-enable alias mirrors fifo control bit 0, enabling both FIFOs.
// - FIFO enable falling from 1 to 0 empties both FIFOs.
// - Receive-trigger alias mirrors fifo control bits 7:6 only.
// - Received-data interrupt rises when receive level reaches the threshold.
// - In transfer mode 1, receive request follows the same threshold.
// - Trigger codes: one, quarter, half, two below full.
module usc_top #(
    parameter int FIFO_DEPTH  = 16,
    parameter int LEVEL_WIDTH = 5
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [31:0]            bus_addr,
    input  wire logic [15:0]            bus_wdata,
    input  wire logic                   bus_write,
    input  wire logic                   bus_read,
    output logic      [15:0]            bus_rdata,
    input  wire logic                   tx_serial_raw,
    input  wire logic                   infrared_raw,
    input  wire logic                   rx_serial_line,
    input  wire logic [LEVEL_WIDTH-1:0] tx_fifo_level,
    input  wire logic                   rx_push,
    input  wire logic                   rx_pop,
    output logic                        serial_out_line,
    output logic                        infrared_out_line,
    output logic                        receiver_in_line,
    output logic                        tx_fifo_flush,
    output logic      [LEVEL_WIDTH-1:0] rx_fifo_level,
    output logic                        tx_transfer_request,
    output logic                        rx_transfer_request,
    output logic                        irq
);
    usc_rxq_if #(.LEVEL_WIDTH(LEVEL_WIDTH)) rxq ();

    usc_rx_level #(
        .FIFO_DEPTH  (FIFO_DEPTH),
        .LEVEL_WIDTH (LEVEL_WIDTH)
    ) u_rx_level (
        .clock (clock),
        .rst   (rst),
        .rxq   (rxq)
    );

    function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
        hit = (addr == offset);
    endfunction : hit

    function automatic logic [LEVEL_WIDTH-1:0] threshold(input logic [1:0] code,
                                                          input logic       fifo_on);
        logic [LEVEL_WIDTH-1:0] value;
        value = LEVEL_WIDTH'(1);
        if (fifo_on) begin
            case (code)
                usc_pkg::TRIG_ONE:     value = LEVEL_WIDTH'(1);
                usc_pkg::TRIG_QUARTER: value = LEVEL_WIDTH'(FIFO_DEPTH / 4);
                usc_pkg::TRIG_HALF:    value = LEVEL_WIDTH'(FIFO_DEPTH / 2);
                usc_pkg::TRIG_TWO_OFF: value = LEVEL_WIDTH'(FIFO_DEPTH - 2);
                default:               value = LEVEL_WIDTH'(1);
            endcase
        end
        threshold = value;
    endfunction : threshold

    logic [7:0]             line_control_reg;
    logic [7:0]             modem_control_reg;
    logic [7:0]             fifo_control_reg;
    logic [7:0]             fifo_control_next;
    logic [1:0]             int_status_reg;
    logic [1:0]             int_mask_reg;
    logic [15:0]            rdata_reg;
    logic [15:0]            rdata_next;
    logic                   flush_rx_reg;
    logic                   flush_tx_reg;
    logic                   pulse_reg;
    logic                   above_reg;
    logic [2:0]             rx_sync_reg;
    logic                   rx_stable_reg;
    logic                   break_on;
    logic                   loopback_on;
    logic                   ir_break;
    logic                   fifo_on;
    logic                   mode_one;
    logic                   fifo_off_event;
    logic                   above;
    logic [LEVEL_WIDTH-1:0] rx_threshold;
    logic [1:0]             int_events;

    assign break_on    = line_control_reg[usc_pkg::BREAK_BIT];
    assign loopback_on = modem_control_reg[usc_pkg::LOOPBACK_BIT];
    assign ir_break    = modem_control_reg[usc_pkg::INFRARED_BIT] && break_on && !loopback_on;
    assign fifo_on     = fifo_control_reg[usc_pkg::FIFO_ON_BIT];
    assign mode_one    = fifo_control_reg[usc_pkg::MODE_BIT];

    // Both paths land in the same flip-flop, so no copy can go stale.
    always_ff @(posedge clock) begin
        if (rst) begin
            line_control_reg <= usc_pkg::LINE_CONTROL_RESET;
        end else if (bus_write && hit(bus_addr, usc_pkg::LINE_CONTROL_OFFSET)) begin
            line_control_reg <= bus_wdata[7:0];
        end else if (bus_write && hit(bus_addr, usc_pkg::BREAK_ALIAS_OFFSET)) begin
            line_control_reg[usc_pkg::BREAK_BIT] <= bus_wdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            modem_control_reg <= usc_pkg::MODEM_CONTROL_RESET;
        end else if (bus_write && hit(bus_addr, usc_pkg::MODEM_CONTROL_OFFSET)) begin
            modem_control_reg <= bus_wdata[7:0];
        end
    end

    always_comb begin
        fifo_control_next = fifo_control_reg;
        if (bus_write && hit(bus_addr, usc_pkg::FIFO_CONTROL_OFFSET)) begin
            fifo_control_next = bus_wdata[7:0] & usc_pkg::FIFO_STORED_MASK;
        end else if (bus_write && hit(bus_addr, usc_pkg::MODE_ALIAS_OFFSET)) begin
            fifo_control_next[usc_pkg::MODE_BIT] = bus_wdata[0];
        end else if (bus_write && hit(bus_addr, usc_pkg::FIFO_ON_ALIAS_OFFSET)) begin
            fifo_control_next[usc_pkg::FIFO_ON_BIT] = bus_wdata[0];
        end else if (bus_write && hit(bus_addr, usc_pkg::RX_TRIG_ALIAS_OFFSET)) begin
            fifo_control_next[usc_pkg::RX_TRIG_LSB +: 2] = bus_wdata[1:0];
        end
    end

    assign fifo_off_event = fifo_on && !fifo_control_next[usc_pkg::FIFO_ON_BIT];

    always_ff @(posedge clock) begin
        if (rst) begin
            fifo_control_reg <= usc_pkg::FIFO_CONTROL_RESET;
        end else begin
            fifo_control_reg <= fifo_control_next;
        end
    end

    // The reset bits are self-clearing, so they live only as one-cycle flush pulses.
    always_ff @(posedge clock) begin
        if (rst) begin
            flush_rx_reg <= 1'b0;
            flush_tx_reg <= 1'b0;
        end else begin
            flush_rx_reg <= fifo_off_event || (bus_write && bus_wdata[usc_pkg::RX_RESET_BIT]
                            && hit(bus_addr, usc_pkg::FIFO_CONTROL_OFFSET));
            flush_tx_reg <= fifo_off_event || (bus_write && bus_wdata[usc_pkg::TX_RESET_BIT]
                            && hit(bus_addr, usc_pkg::FIFO_CONTROL_OFFSET));
        end
    end

    assign rxq.push      = rx_push;
    assign rxq.pop       = rx_pop;
    assign rxq.flush     = flush_rx_reg;
    assign tx_fifo_flush = flush_tx_reg;
    assign rx_fifo_level = rxq.level;

    assign rx_threshold = threshold(fifo_control_reg[usc_pkg::RX_TRIG_LSB +: 2], fifo_on);
    assign above        = (rxq.level >= rx_threshold);

    always_ff @(posedge clock) begin
        if (rst) begin
            above_reg <= 1'b0;
        end else begin
            above_reg <= above;
        end
    end

    // Mode 0 asks per character; mode 1 asks receive bursts gated by the threshold and transmit whenever not full.
    always_comb begin
        if (mode_one) begin
            rx_transfer_request = above;
            tx_transfer_request = (tx_fifo_level != LEVEL_WIDTH'(FIFO_DEPTH));
        end else begin
            rx_transfer_request = (rxq.level != '0);
            tx_transfer_request = (tx_fifo_level == '0);
        end
    end

    // A clean break ends only when the pin is released, hence the priority order.
    always_comb begin
        if (loopback_on) begin
            serial_out_line = 1'b1;
        end else if (break_on) begin
            serial_out_line = 1'b0;
        end else begin
            serial_out_line = tx_serial_raw;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= ir_break ? !pulse_reg : 1'b0;
        end
    end

    assign infrared_out_line = ir_break ? pulse_reg : infrared_raw;

    // The receive pin is only trusted once the last two stages agree.
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_sync_reg   <= 3'h7;
            rx_stable_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rx_serial_line};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_stable_reg <= rx_sync_reg[2];
            end
        end
    end

    assign receiver_in_line = loopback_on ? (tx_serial_raw && !break_on) : rx_stable_reg;

    assign int_events[usc_pkg::INT_RX_BIT]    = above && !above_reg;
    assign int_events[usc_pkg::INT_FLUSH_BIT] = fifo_off_event;

    // An event in the cycle of the clearing read survives it.
    always_ff @(posedge clock) begin
        if (rst) begin
            int_status_reg <= usc_pkg::INT_RESET;
        end else if (bus_read && hit(bus_addr, usc_pkg::INT_STATUS_OFFSET)) begin
            int_status_reg <= int_events;
        end else begin
            int_status_reg <= int_status_reg | int_events;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            int_mask_reg <= usc_pkg::INT_RESET;
        end else if (bus_write && hit(bus_addr, usc_pkg::INT_MASK_OFFSET)) begin
            int_mask_reg <= bus_wdata[1:0];
        end
    end

    assign irq = |(int_status_reg & int_mask_reg);

    always_comb begin
        rdata_next = 16'h0000;
        if (hit(bus_addr, usc_pkg::BREAK_ALIAS_OFFSET)) begin
            rdata_next[0] = break_on;
        end else if (hit(bus_addr, usc_pkg::MODE_ALIAS_OFFSET)) begin
            rdata_next[0] = mode_one;
        end else if (hit(bus_addr, usc_pkg::FIFO_ON_ALIAS_OFFSET)) begin
            rdata_next[0] = fifo_on;
        end else if (hit(bus_addr, usc_pkg::RX_TRIG_ALIAS_OFFSET)) begin
            rdata_next[1:0] = fifo_control_reg[usc_pkg::RX_TRIG_LSB +: 2];
        end else if (hit(bus_addr, usc_pkg::FIFO_CONTROL_OFFSET)) begin
            rdata_next[7:0] = fifo_control_reg;
        end else if (hit(bus_addr, usc_pkg::LINE_CONTROL_OFFSET)) begin
            rdata_next[7:0] = line_control_reg;
        end else if (hit(bus_addr, usc_pkg::MODEM_CONTROL_OFFSET)) begin
            rdata_next[7:0] = modem_control_reg;
        end else if (hit(bus_addr, usc_pkg::INT_STATUS_OFFSET)) begin
            rdata_next[1:0] = int_status_reg;
        end else if (hit(bus_addr, usc_pkg::INT_MASK_OFFSET)) begin
            rdata_next[1:0] = int_mask_reg;
        end else if (hit(bus_addr, usc_pkg::RX_LEVEL_OFFSET)) begin
            rdata_next[LEVEL_WIDTH-1:0] = rxq.level;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= bus_read ? rdata_next : 16'h0000;
        end
    end

    assign bus_rdata = rdata_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_mode_alias_write;
        bus_write && hit(bus_addr, usc_pkg::MODE_ALIAS_OFFSET);
    endsequence

    sequence s_fifo_control_read;
        bus_read && hit(bus_addr, usc_pkg::FIFO_CONTROL_OFFSET);
    endsequence

    a_break_holds_low: assert property (
        break_on && !loopback_on |-> !serial_out_line ##1 (break_on || serial_out_line
            || !tx_serial_raw || loopback_on))
        else $error("Break did not hold or release the serial output.");

    a_break_alias_path: assert property (
        bus_write && hit(bus_addr, usc_pkg::BREAK_ALIAS_OFFSET)
        |=> line_control_reg[usc_pkg::BREAK_BIT] == $past(bus_wdata[0])
            && line_control_reg[5:0] == $past(line_control_reg[5:0]))
        else $error("Break alias did not reach line control bit.");

    a_infrared_keeps_pulsing: assert property (
        ir_break [*3] |-> infrared_out_line != $past(infrared_out_line))
        else $error("Infrared output stopped pulsing during break.");

    a_loopback_break_inside: assert property (
        loopback_on && break_on |-> serial_out_line && !receiver_in_line)
        else $error("Loopback break leaked to the pin.");

    a_mode_alias_only: assert property (
        s_mode_alias_write |=> fifo_control_reg[usc_pkg::MODE_BIT] == $past(bus_wdata[0])
            && fifo_control_reg[7:4] == $past(fifo_control_reg[7:4])
            && fifo_control_reg[0] == $past(fifo_control_reg[0]))
        else $error("Transfer-mode alias disturbed other fields.");

    a_rx_request_mode: assert property (
        rxq.level == '0 |-> !rx_transfer_request ##0 (!mode_one || above
            || !rx_transfer_request))
        else $error("Receive request ignored the selected mode.");

    a_fifo_off_flush: assert property (
        $fell(fifo_on) |-> flush_rx_reg && tx_fifo_flush ##1 rxq.level == '0)
        else $error("Disabling the FIFOs did not empty them.");

    a_trigger_alias_only: assert property (
        bus_write && hit(bus_addr, usc_pkg::RX_TRIG_ALIAS_OFFSET)
        |=> fifo_control_reg[7:6] == $past(bus_wdata[1:0])
            && fifo_control_reg[5:0] == $past(fifo_control_reg[5:0]))
        else $error("Receive-trigger alias disturbed other fields.");

    a_rx_interrupt_raise: assert property (
        $rose(above) && int_mask_reg[usc_pkg::INT_RX_BIT] && !rst |=> irq)
        else $error("Threshold reached without an interrupt.");

    a_threshold_map: assert property (
        fifo_on && fifo_control_reg[7:6] == usc_pkg::TRIG_TWO_OFF
        |-> rx_threshold == LEVEL_WIDTH'(FIFO_DEPTH - 2))
        else $error("Trigger code 3 gave the wrong threshold.");

    a_alias_readback: assert property (
        s_mode_alias_write ##1 s_fifo_control_read
        |=> bus_rdata[usc_pkg::MODE_BIT] == $past(bus_wdata[0], 2))
        else $error("Control register read missed the alias write.");
endmodule : usc_top

// ==== verilog/usc_pkg.sv ====
package usc_pkg;
    localparam logic [31:0] BREAK_ALIAS_OFFSET     = 32'h5000_1090;
    localparam logic [31:0] MODE_ALIAS_OFFSET      = 32'h5000_1094;
    localparam logic [31:0] FIFO_ON_ALIAS_OFFSET   = 32'h5000_1098;
    localparam logic [31:0] RX_TRIG_ALIAS_OFFSET   = 32'h5000_109c;
    localparam logic [31:0] FIFO_CONTROL_OFFSET    = 32'h5000_1008;
    localparam logic [31:0] LINE_CONTROL_OFFSET    = 32'h5000_100c;
    localparam logic [31:0] MODEM_CONTROL_OFFSET   = 32'h5000_1010;
    localparam logic [31:0] INT_STATUS_OFFSET      = 32'h5000_10b0;
    localparam logic [31:0] INT_MASK_OFFSET        = 32'h5000_10b4;
    localparam logic [31:0] RX_LEVEL_OFFSET        = 32'h5000_10b8;

    localparam int BREAK_BIT     = 6;
    localparam int LOOPBACK_BIT  = 4;
    localparam int INFRARED_BIT  = 6;
    localparam int FIFO_ON_BIT   = 0;
    localparam int RX_RESET_BIT  = 1;
    localparam int TX_RESET_BIT  = 2;
    localparam int MODE_BIT      = 3;
    localparam int TX_TRIG_LSB   = 4;
    localparam int RX_TRIG_LSB   = 6;
    localparam int INT_RX_BIT    = 0;
    localparam int INT_FLUSH_BIT = 1;

    localparam logic [7:0] LINE_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
    localparam logic [7:0] FIFO_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] FIFO_STORED_MASK    = 8'hf9;
    localparam logic [1:0] INT_RESET           = 2'h0;

    localparam logic [1:0] TRIG_ONE     = 2'h0;
    localparam logic [1:0] TRIG_QUARTER = 2'h1;
    localparam logic [1:0] TRIG_HALF    = 2'h2;
    localparam logic [1:0] TRIG_TWO_OFF = 2'h3;
endpackage : usc_pkg

// ==== verilog/usc_rxq_if.sv ====
`timescale 1ns/10ps
interface usc_rxq_if #(parameter int LEVEL_WIDTH = 5);
    logic                   push;
    logic                   pop;
    logic                   flush;
    logic [LEVEL_WIDTH-1:0] level;
    logic                   full;

    modport ctrl (output push, output pop, output flush, input level, input full);
    modport count (input push, input pop, input flush, output level, output full);
endinterface : usc_rxq_if

// ==== verilog/usc_rx_level.sv ====
`timescale 1ns/10ps
module usc_rx_level #(
    parameter int FIFO_DEPTH  = 16,
    parameter int LEVEL_WIDTH = 5
) (
    input  wire logic clock,
    input  wire logic rst,
    usc_rxq_if.count  rxq
);
    logic [LEVEL_WIDTH-1:0] level_reg;
    logic                   take;
    logic                   give;

    // A push into a full queue or a pop from an empty one is dropped.
    assign take = rxq.push && (level_reg != LEVEL_WIDTH'(FIFO_DEPTH));
    assign give = rxq.pop && (level_reg != '0);

    always_ff @(posedge clock) begin
        if (rst || rxq.flush) begin
            level_reg <= '0;
        end else if (take && !give) begin
            level_reg <= level_reg + 1'b1;
        end else if (give && !take) begin
            level_reg <= level_reg - 1'b1;
        end
    end

    assign rxq.level = level_reg;
    assign rxq.full  = (level_reg == LEVEL_WIDTH'(FIFO_DEPTH));
endmodule : usc_rx_level

// ==== test/usc_remote.sv ====
`timescale 1ns/10ps
// Far-end serial device in echo mode: returns our serial output and watches it for a break.
module usc_remote (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic serial_out_line,
    output logic      rx_serial_line,
    output logic      break_seen
);
    logic [3:0] low_count_reg;
    logic       echo_reg;

    // The echo starts at mark, so the receive path never sees a false start after reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            echo_reg <= 1'b1;
        end else begin
            echo_reg <= serial_out_line;
        end
    end

    assign rx_serial_line = echo_reg;

    // A break is any low run longer than a character frame could hold low.
    always_ff @(posedge clock) begin
        if (rst || serial_out_line) begin
            low_count_reg <= 4'h0;
        end else if (low_count_reg != 4'hf) begin
            low_count_reg <= low_count_reg + 4'h1;
        end
    end

    assign break_seen = (low_count_reg >= 4'h8);
endmodule : usc_remote

// ==== test/uart_shadow_control_bits_bench.sv ====
`timescale 1ns/10ps
module uart_shadow_control_bits_bench;
    typedef struct {
        logic [31:0] wa;
        logic [15:0] wd;
        logic [31:0] ra;
        logic [15:0] re;
        logic [31:0] rb;
        logic [15:0] rbe;
    } usc_row_type;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] bus_addr = 32'h0000_0000;
    logic [15:0] bus_wdata = 16'h0000;
    logic        bus_write = 1'b0;
    logic        bus_read = 1'b0;
    logic [15:0] bus_rdata;
    logic        tx_serial_raw = 1'b1;
    logic        infrared_raw = 1'b0;
    logic        rx_serial_line;
    logic [4:0]  tx_fifo_level = 5'h00;
    logic        rx_push = 1'b0;
    logic        rx_pop = 1'b0;
    logic        serial_out_line;
    logic        infrared_out_line;
    logic        receiver_in_line;
    logic        tx_fifo_flush;
    logic [4:0]  rx_fifo_level;
    logic        tx_transfer_request;
    logic        rx_transfer_request;
    logic        irq;
    logic        break_seen;
    logic        ir_a;
    int          err_total = 0;
    int          tests_run = 0;
    int          thr[4] = '{1, 4, 8, 14};
    usc_row_type rows[6] = '{
        '{usc_pkg::BREAK_ALIAS_OFFSET, 16'h0001, usc_pkg::BREAK_ALIAS_OFFSET, 16'h0001,
          usc_pkg::LINE_CONTROL_OFFSET, 16'h0040},
        '{usc_pkg::MODE_ALIAS_OFFSET, 16'h0001, usc_pkg::MODE_ALIAS_OFFSET, 16'h0001,
          usc_pkg::FIFO_CONTROL_OFFSET, 16'h0008},
        '{usc_pkg::FIFO_ON_ALIAS_OFFSET, 16'h0001, usc_pkg::FIFO_ON_ALIAS_OFFSET, 16'h0001,
          usc_pkg::FIFO_CONTROL_OFFSET, 16'h0009},
        '{usc_pkg::RX_TRIG_ALIAS_OFFSET, 16'h0003, usc_pkg::RX_TRIG_ALIAS_OFFSET, 16'h0003,
          usc_pkg::FIFO_CONTROL_OFFSET, 16'h00c9},
        '{usc_pkg::FIFO_CONTROL_OFFSET, 16'h0041, usc_pkg::RX_TRIG_ALIAS_OFFSET, 16'h0001,
          usc_pkg::MODE_ALIAS_OFFSET, 16'h0000},
        '{usc_pkg::LINE_CONTROL_OFFSET, 16'h0000, usc_pkg::BREAK_ALIAS_OFFSET, 16'h0000,
          usc_pkg::FIFO_ON_ALIAS_OFFSET, 16'h0001}
    };

    usc_top u_dut (
        .clock               (clock),
        .rst                 (rst),
        .bus_addr            (bus_addr),
        .bus_wdata           (bus_wdata),
        .bus_write           (bus_write),
        .bus_read            (bus_read),
        .bus_rdata           (bus_rdata),
        .tx_serial_raw       (tx_serial_raw),
        .infrared_raw        (infrared_raw),
        .rx_serial_line      (rx_serial_line),
        .tx_fifo_level       (tx_fifo_level),
        .rx_push             (rx_push),
        .rx_pop              (rx_pop),
        .serial_out_line     (serial_out_line),
        .infrared_out_line   (infrared_out_line),
        .receiver_in_line    (receiver_in_line),
        .tx_fifo_flush       (tx_fifo_flush),
        .rx_fifo_level       (rx_fifo_level),
        .tx_transfer_request (tx_transfer_request),
        .rx_transfer_request (rx_transfer_request),
        .irq                 (irq)
    );

    usc_remote u_remote (
        .clock           (clock),
        .rst             (rst),
        .serial_out_line (serial_out_line),
        .rx_serial_line  (rx_serial_line),
        .break_seen      (break_seen)
    );

    always #25 clock = ~clock;

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clock);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clock);
        bus_read <= 1'b0;
        #1;
        chk16(bus_rdata, exp);
    endtask : rd

    task automatic wr_rd(input logic [31:0] wa, input logic [15:0] wd, input logic [31:0] ra,
                         input logic [15:0] exp);
        @(posedge clock);
        bus_addr  <= wa;
        bus_wdata <= wd;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
        bus_addr  <= ra;
        bus_read  <= 1'b1;
        @(posedge clock);
        bus_read <= 1'b0;
        #1;
        chk16(bus_rdata, exp);
    endtask : wr_rd

    task automatic push;
        @(posedge clock);
        rx_push <= 1'b1;
        @(posedge clock);
        rx_push <= 1'b0;
        @(posedge clock);
        #1;
    endtask : push

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(usc_pkg::BREAK_ALIAS_OFFSET + 32'(4 * i), 16'h0000);
        end
        rd(32'h5000_10fc, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].re);
            rd(rows[i].rb, rows[i].rbe);
        end
        // Break through the alias, with reserved bits written high to prove they read back 0.
        wr(usc_pkg::BREAK_ALIAS_OFFSET, 16'hffff);
        rd(usc_pkg::BREAK_ALIAS_OFFSET, 16'h0001);
        repeat (10) @(posedge clock);
        #1;
        chk1(serial_out_line, 1'b0);
        chk1(break_seen, 1'b1);
        chk1(receiver_in_line, 1'b0);
        wr(usc_pkg::MODEM_CONTROL_OFFSET, 16'h0040);
        repeat (3) @(posedge clock);
        #1;
        ir_a = infrared_out_line;
        @(posedge clock);
        #1;
        chk1(infrared_out_line, ~ir_a);
        wr(usc_pkg::MODEM_CONTROL_OFFSET, 16'h0010);
        @(posedge clock);
        #1;
        chk1(receiver_in_line, 1'b0);
        chk1(serial_out_line, 1'b1);
        wr(usc_pkg::MODEM_CONTROL_OFFSET, 16'h0000);
        wr(usc_pkg::BREAK_ALIAS_OFFSET, 16'h0000);
        @(posedge clock);
        #1;
        chk1(serial_out_line, 1'b1);
        // Thresholds for every trigger code, with requests in mode 1 and interrupt unmasked.
        wr_rd(usc_pkg::MODE_ALIAS_OFFSET, 16'h0001, usc_pkg::FIFO_CONTROL_OFFSET, 16'h0049);
        wr(usc_pkg::INT_MASK_OFFSET, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            wr(usc_pkg::FIFO_ON_ALIAS_OFFSET, 16'h0001);
            wr(usc_pkg::RX_TRIG_ALIAS_OFFSET, 16'(c));
            for (int p = 1; p < thr[c]; p++) begin
                push();
            end
            chk1(rx_transfer_request, 1'b0);
            chk1(irq, 1'b0);
            push();
            chk1(rx_transfer_request, 1'b1);
            for (int w = 0; w < 6 && irq !== 1'b1; w++) begin
                @(posedge clock);
                #1;
            end
            chk1(irq, 1'b1);
            rd(usc_pkg::INT_STATUS_OFFSET, 16'h0001);
            wr(usc_pkg::FIFO_ON_ALIAS_OFFSET, 16'h0000);
            #1;
            chk1(tx_fifo_flush, 1'b1);
            repeat (3) @(posedge clock);
            #1;
            chk16({11'h000, rx_fifo_level}, 16'h0000);
            rd(usc_pkg::INT_STATUS_OFFSET, 16'h0002);
        end
        @(posedge clock);
        tx_fifo_level <= 5'h10;
        @(posedge clock);
        #1;
        chk1(tx_transfer_request, 1'b0);
        // Mode 0 requests on any data, with the interrupt masked off.
        wr(usc_pkg::INT_MASK_OFFSET, 16'h0000);
        wr(usc_pkg::MODE_ALIAS_OFFSET, 16'h0000);
        wr(usc_pkg::RX_TRIG_ALIAS_OFFSET, 16'h0003);
        @(posedge clock);
        tx_fifo_level <= 5'h00;
        push();
        chk1(rx_transfer_request, 1'b1);
        chk1(tx_transfer_request, 1'b1);
        @(posedge clock);
        rx_pop <= 1'b1;
        @(posedge clock);
        rx_pop <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk1(rx_transfer_request, 1'b0);
        chk1(irq, 1'b0);
        rd(usc_pkg::INT_STATUS_OFFSET, 16'h0001);
        // The reset bits of the fifo control register pulse a flush and never read back.
        wr(usc_pkg::FIFO_CONTROL_OFFSET, 16'h0006);
        #1;
        chk1(tx_fifo_flush, 1'b1);
        rd(usc_pkg::FIFO_CONTROL_OFFSET, 16'h0000);
        chk1(receiver_in_line, 1'b1);
        results();
    end

    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        results();
    end
endmodule : uart_shadow_control_bits_bench
